/* File: hw/bac_char_proc.sv */
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module bac_char_proc #(
	parameter int TX_DEPTH_P    = bac_pkg::TX_DEPTH,
	parameter int RX_DEPTH_P    = bac_pkg::RX_DEPTH,
	parameter int DELAY_CYCLES  = bac_pkg::DELAY_UNIT_CYCLES
) (
	input  wire logic                        sys_clk,
	input  wire logic                        resetn,
	input  wire logic [bac_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [7:0]                  regWrData,
	input  wire logic                        regWr,
	input  wire logic                        regRd,
	output logic [7:0]                       regRdData,
	output logic                             hostTxReady,
	input  wire logic                        rxCharValid,
	input  wire bac_pkg::bac_rx_char_t       rxChar,
	output logic                             txCharValid,
	output bac_pkg::bac_tx_char_t            txChar,
	input  wire logic                        txCharAccept
);
	import bac_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] maskChar(input logic [7:0] c, input logic [3:0] bitsCode);
		logic [7:0] m;
		m = 8'hFF;
		if (bitsCode == DBITS_5)
			m = 8'h1F;
		else if (bitsCode == DBITS_6)
			m = 8'h3F;
		else if (bitsCode == DBITS_7)
			m = 8'h7F;
		return c & m;
	endfunction

	function automatic logic [7:0] incPtr(input logic [7:0] p, input int depth);
		logic [7:0] last;
		last = 8'(depth - 1);
		return (p == last) ? 8'h00 : 8'(p + 8'h01);
	endfunction

	// ****************************************
	// storage
	// ****************************************
	logic [7:0]    ctl_q [0:CTL_BYTES-1];
	logic [7:0]    txTbl [0:TBL_SIZE-1];
	logic [7:0]    rxTbl [0:TBL_SIZE-1];
	logic [7:0]    txBuf [0:TX_DEPTH_P-1];
	logic [7:0]    rxBuf [0:RX_DEPTH_P-1];
	logic          txXlat_q;
	logic          rxXlat_q;
	logic [7:0]    txHead_q;
	logic [7:0]    txTail_q;
	logic [7:0]    txCount_q;
	logic [7:0]    txCount_d;
	logic [7:0]    rxHead_q;
	logic [7:0]    rxTail_q;
	logic [7:0]    rxCount_q;
	logic [7:0]    recCount_q;
	logic          pendValid_q;
	logic [7:0]    pendChar_q;
	logic [2:0]    errSticky_q;
	logic          rxShift_q;
	logic [1:0]    txShift_q;
	bac_tx_state_t txState_q;
	logic [7:0]    lastChar_q;
	logic          lastWasChar_q;
	logic [7:0]    delayUnits_q;
	logic [31:0]   tickCnt_q;

	// ****************************************
	// register decode
	// ****************************************
	wire [3:0]  page       = regAddr[11:8];
	wire [7:0]  low        = regAddr[7:0];
	wire        ctlHit     = (page == PAGE_CTL) && (low < 8'(CTL_BYTES));
	wire        ctlWr      = regWr && ctlHit;
	wire        txTblWr    = regWr && (page == PAGE_TX_TBL);
	wire        rxTblWr    = regWr && (page == PAGE_RX_TBL);
	wire        txDataWr   = regWr && (regAddr == REG_TX_DATA);
	wire        rxDataRd   = regRd && (regAddr == REG_RX_DATA);
	wire        statusRd   = regRd && (regAddr == REG_STATUS);
	wire [3:0]  dataBits   = ctl_q[CTL_FORMAT-1][7:4];
	wire        shiftOn    = txXlat_q && rxXlat_q && ((dataBits == DBITS_5) || (dataBits == DBITS_6));
	wire        eorOn      = (ctl_q[CTL_EOR-1] == EOR_ENABLE) && rxXlat_q;
	wire [7:0]  upCode     = maskChar(ctl_q[CTL_UPSHIFT-1], dataBits);
	wire [7:0]  dnCode     = maskChar(ctl_q[CTL_DNSHIFT-1], dataBits);

	// ****************************************
	// host transmit side
	// ****************************************
	wire        txFull     = (txCount_q == 8'(TX_DEPTH_P));
	// host char translated before it enters the buffer
	wire [7:0]  hostChar   = pendValid_q ? pendChar_q : regWrData;
	wire [7:0]  txIn       = txXlat_q ? txTbl[hostChar] : hostChar;
	wire        txPush     = !txFull && (pendValid_q || txDataWr);
	wire        txHold     = txDataWr && (txFull || pendValid_q);
	wire [7:0]  txHeadChar = txBuf[txHead_q];

	// ****************************************
	// transmit sequencing
	// ****************************************
	// shift code only goes out when a shifted char changes status
	wire        needShift  = shiftOn && !txHeadChar[7] && (txHeadChar[7:6] != txShift_q);
	wire        txStart    = (txState_q == TX_IDLE) && (txCount_q != 8'h00);
	wire        txPop      = txStart && !needShift;
	wire [7:0]  txOutData  = needShift ? ((txHeadChar[6]) ? upCode : dnCode) : txHeadChar;
	wire        tick       = (tickCnt_q == 32'(DELAY_CYCLES - 1));

	logic [7:0] pairDelay;
	always_comb
	begin
		pairDelay = 8'h00;
		for (int i = PAIR_COUNT - 1; i >= 0; i--)
		begin
			if (ctl_q[CTL_PAIR_BASE - 1 + 2 * i] == lastChar_q)
				pairDelay = ctl_q[CTL_PAIR_BASE + 2 * i];
		end
	end

	always_comb
	begin
		txCount_d = txCount_q;
		if (txPush && !txPop)
			txCount_d = 8'(txCount_q + 8'h01);
		else if (!txPush && txPop)
			txCount_d = 8'(txCount_q - 8'h01);
	end

	// ****************************************
	// receive side
	// ****************************************
	wire        rxErr      = rxChar.parityErr || rxChar.framingErr;
	wire [7:0]  rxLow      = maskChar(rxChar.data, dataBits);
	// idle lines between characters must never move the shift state
	wire        rxIsUp     = rxCharValid && shiftOn && !rxErr && (rxLow == upCode);
	wire        rxIsDn     = rxCharValid && shiftOn && !rxErr && (rxLow == dnCode);
	wire [7:0]  rxIdx      = shiftOn ? {rxShift_q, rxLow[6:0]} : rxChar.data;
	wire [7:0]  rxXl       = rxXlat_q ? rxTbl[rxIdx] : rxIdx;
	wire [7:0]  rxStore    = rxErr ? ctl_q[CTL_SUBST-1] : rxXl;
	wire        nullDrop   = !rxErr && (ctl_q[CTL_MODE-1][7:4] == MODE_NULL_DROP) && (rxXl == 8'h00);
	wire        rxKeep     = rxCharValid && !rxIsUp && !rxIsDn && !nullDrop;
	wire        rxFull     = (rxCount_q == 8'(RX_DEPTH_P));
	wire        rxPush     = rxKeep && !rxFull;
	wire        rxOverflow = rxKeep && rxFull;
	wire        delimIn    = rxPush && eorOn && rxStore[7];
	wire [7:0]  rxHeadChar = rxBuf[rxHead_q];
	// with records on, nothing past the last complete record is readable
	wire        rxCanRead  = (rxCount_q != 8'h00) && (!eorOn || (recCount_q != 8'h00));
	wire        rxPop      = rxDataRd && rxCanRead;
	wire        delimOut   = rxPop && eorOn && rxHeadChar[7];
	wire [7:0]  rxOutChar  = eorOn ? {1'b0, rxHeadChar[6:0]} : rxHeadChar;
	wire [2:0]  errSet     = {rxOverflow, rxCharValid && rxChar.framingErr, rxCharValid && rxChar.parityErr};
	logic [7:0] statusByte;
	always_comb
	begin
		statusByte              = 8'h00;
		statusByte[ST_PARITY]   = errSticky_q[0];
		statusByte[ST_FRAMING]  = errSticky_q[1];
		statusByte[ST_OVERFLOW] = errSticky_q[2];
		statusByte[ST_RX_AVAIL] = rxCanRead;
		statusByte[ST_TX_READY] = !txFull && !pendValid_q;
	end

	// ****************************************
	// read mux
	// ****************************************
	wire [7:0]  rdMux =
		ctlHit                     ? ctl_q[low[4:0]] :
		(page == PAGE_TX_TBL)      ? txTbl[low] :
		(page == PAGE_RX_TBL)      ? rxTbl[low] :
		(regAddr == REG_RX_DATA)   ? (rxCanRead ? rxOutChar : 8'h00) :
		(regAddr == REG_STATUS)    ? statusByte :
		(regAddr == REG_REC_COUNT) ? recCount_q :
		(regAddr == REG_RX_LEVEL)  ? rxCount_q :
		(regAddr == REG_TX_LEVEL)  ? txCount_q :
		8'h00;

	// ****************************************
	// host registers and tables
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < CTL_BYTES; i++)
				ctl_q[i] <= CTL_RESET;
			regRdData <= 8'h00;
		end
		else
		begin
			if (ctlWr)
				ctl_q[low[4:0]] <= regWrData;
			regRdData <= regRd ? rdMux : 8'h00;
		end
	end

	// tables hold no reset; loading one is what enables it
	always_ff @(posedge sys_clk)
	begin
		if (txTblWr)
			txTbl[low] <= regWrData;
		if (rxTblWr)
			rxTbl[low] <= regWrData;
	end

	// a control vector write disables translation until tables follow
	always_ff @(posedge sys_clk)
	begin
		if (!resetn || ctlWr)
		begin
			txXlat_q <= 1'b0;
			rxXlat_q <= 1'b0;
		end
		else
		begin
			if (txTblWr)
				txXlat_q <= 1'b1;
			if (rxTblWr)
				rxXlat_q <= 1'b1;
		end
	end

	// error bits sticky, cleared by status read; a new error wins
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			errSticky_q <= 3'b000;
		else
			errSticky_q <= (statusRd ? 3'b000 : errSticky_q) | errSet;
	end

	// ****************************************
	// transmit buffer
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (txPush)
			txBuf[txTail_q] <= txIn;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			txHead_q    <= 8'h00;
			txTail_q    <= 8'h00;
			txCount_q   <= 8'h00;
			pendValid_q <= 1'b0;
			pendChar_q  <= 8'h00;
			hostTxReady <= 1'b0;
		end
		else
		begin
			if (txPush)
				txTail_q <= incPtr(txTail_q, TX_DEPTH_P);
			if (txPop)
				txHead_q <= incPtr(txHead_q, TX_DEPTH_P);
			txCount_q <= txCount_d;
			// a write into a full buffer waits here for room
			if (txHold)
			begin
				pendValid_q <= 1'b1;
				pendChar_q  <= regWrData;
			end
			else if (txPush)
				pendValid_q <= 1'b0;
			hostTxReady <= !(txHold || (pendValid_q && !txPush)) && (txCount_d != 8'(TX_DEPTH_P));
		end
	end

	// ****************************************
	// transmit sequencer
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			txState_q     <= TX_IDLE;
			txCharValid   <= 1'b0;
			txChar        <= '0;
			txShift_q     <= SHIFT_NONE;
			lastChar_q    <= 8'h00;
			lastWasChar_q <= 1'b0;
			delayUnits_q  <= 8'h00;
			tickCnt_q     <= 32'h0000_0000;
		end
		else
		begin
			unique case (txState_q)
				TX_IDLE:
				begin
					if (txStart)
					begin
						txCharValid      <= 1'b1;
						txChar.data      <= maskChar(txOutData, dataBits);
						txChar.dataBits  <= dataBits;
						lastChar_q       <= txHeadChar;
						lastWasChar_q    <= !needShift;
						if (needShift)
							txShift_q <= txHeadChar[7:6];
						txState_q        <= TX_SEND;
					end
				end
				TX_SEND:
				begin
					if (txCharAccept)
					begin
						txCharValid  <= 1'b0;
						tickCnt_q    <= 32'h0000_0000;
						delayUnits_q <= pairDelay;
						if (lastWasChar_q && (pairDelay != 8'h00))
							txState_q <= TX_DELAY;
						else
							txState_q <= TX_IDLE;
					end
				end
				TX_DELAY:
				begin
					tickCnt_q <= tick ? 32'h0000_0000 : 32'(tickCnt_q + 32'h1);
					if (tick)
					begin
						delayUnits_q <= 8'(delayUnits_q - 8'h01);
						if (delayUnits_q == 8'h01)
							txState_q <= TX_IDLE;
					end
				end
				default:
					txState_q <= TX_IDLE;
			endcase
		end
	end

	// ****************************************
	// receive buffer
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rxPush)
			rxBuf[rxTail_q] <= rxStore;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rxHead_q   <= 8'h00;
			rxTail_q   <= 8'h00;
			rxCount_q  <= 8'h00;
			recCount_q <= 8'h00;
			rxShift_q  <= 1'b0;
		end
		else
		begin
			if (rxIsUp)
				rxShift_q <= 1'b1;
			else if (rxIsDn)
				rxShift_q <= 1'b0;
			if (rxPush)
				rxTail_q <= incPtr(rxTail_q, RX_DEPTH_P);
			if (rxPop)
				rxHead_q <= incPtr(rxHead_q, RX_DEPTH_P);
			if (rxPush && !rxPop)
				rxCount_q <= 8'(rxCount_q + 8'h01);
			else if (!rxPush && rxPop)
				rxCount_q <= 8'(rxCount_q - 8'h01);
			if (delimIn && !delimOut)
				recCount_q <= 8'(recCount_q + 8'h01);
			else if (!delimIn && delimOut)
				recCount_q <= 8'(recCount_q - 8'h01);
		end
	end
endmodule

/* File: hw/bac_pkg.sv */
package bac_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam int          ADDR_W        = 12;
	localparam int          CTL_BYTES     = 20;
	localparam logic [11:0] REG_TX_DATA   = 12'h020;
	localparam logic [11:0] REG_RX_DATA   = 12'h021;
	localparam logic [11:0] REG_STATUS    = 12'h022;
	localparam logic [11:0] REG_REC_COUNT = 12'h023;
	localparam logic [11:0] REG_RX_LEVEL  = 12'h024;
	localparam logic [11:0] REG_TX_LEVEL  = 12'h025;
	localparam logic [3:0]  PAGE_CTL      = 4'h0;
	localparam logic [3:0]  PAGE_TX_TBL   = 4'h1;
	localparam logic [3:0]  PAGE_RX_TBL   = 4'h2;

	// control vector byte numbers, byte n at address n-1
	localparam int          CTL_MODE      = 2;
	localparam int          CTL_FORMAT    = 3;
	localparam int          CTL_SUBST     = 4;
	localparam int          CTL_EOR       = 6;
	localparam int          CTL_UPSHIFT   = 7;
	localparam int          CTL_DNSHIFT   = 8;
	localparam int          CTL_PAIR_BASE = 11;
	localparam int          PAIR_COUNT    = 4;
	localparam logic [3:0]  MODE_NULL_DROP = 4'h1;
	localparam logic [7:0]  EOR_ENABLE    = 8'h01;
	localparam logic [3:0]  DBITS_5       = 4'h0;
	localparam logic [3:0]  DBITS_6       = 4'h1;
	localparam logic [3:0]  DBITS_7       = 4'h2;
	localparam logic [7:0]  CTL_RESET     = 8'h00;

	// status byte bits
	localparam int          ST_PARITY     = 0;
	localparam int          ST_FRAMING    = 1;
	localparam int          ST_OVERFLOW   = 2;
	localparam int          ST_RX_AVAIL   = 3;
	localparam int          ST_TX_READY   = 4;

	// ****************************************
	// sizes and timing
	// ****************************************
	localparam int          TX_DEPTH      = 200;
	localparam int          RX_DEPTH      = 255;
	localparam int          TBL_SIZE      = 256;
	localparam int          CLK_HZ        = 25_000_000;
	localparam int          DELAY_UNIT_MS = 10;
	localparam int          DELAY_UNIT_CYCLES = CLK_HZ / 1000 * DELAY_UNIT_MS;
	localparam logic [1:0]  SHIFT_DOWN    = 2'b00;
	localparam logic [1:0]  SHIFT_UP      = 2'b01;
	localparam logic [1:0]  SHIFT_NONE    = 2'b10;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic [7:0] data;
		logic       parityErr;
		logic       framingErr;
	} bac_rx_char_t;

	typedef struct packed {
		logic [7:0] data;
		logic [3:0] dataBits;
	} bac_tx_char_t;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_SEND  = 2'b01,
		TX_DELAY = 2'b10
	} bac_tx_state_t;
endpackage

/* File: sim/bac_char_proc_sva.sv */
`timescale 1ns/1ns
module bac_char_proc_sva #(
	parameter int	DELAY_CYCLES = bac_pkg::DELAY_UNIT_CYCLES
) (
	input	wire logic	sys_clk,
	input	wire logic	resetn,
	input	wire logic [bac_pkg::ADDR_W-1:0]	regAddr,
	input	wire logic [7:0]	regWrData,
	input	wire logic	regWr,
	input	wire logic	regRd,
	input	wire logic [7:0]	regRdData,
	input	wire logic	hostTxReady,
	input	wire logic	rxCharValid,
	input	wire bac_pkg::bac_rx_char_t	rxChar,
	input	wire logic	txCharValid,
	input	wire bac_pkg::bac_tx_char_t	txChar,
	input	wire logic	txCharAccept
);
	import bac_pkg::*;
	// ****************************************
	// shadow of the control bytes the checks need
	// ****************************************
	logic [7:0]	ctl_q [CTL_BYTES];
	logic	rxt_q;
	logic [31:0]	gap_q;
	wire	ctlWr = regWr && regAddr < CTL_BYTES;
	wire	rxTblWr = regWr && regAddr[11:8] == PAGE_RX_TBL;
	wire	eorOn = ctl_q[CTL_EOR-1] == EOR_ENABLE && rxt_q;
	// pair 1 only: it wins over the others on a shared character
	wire	pauseHit = txCharValid && txCharAccept && ctl_q[CTL_FORMAT-1][7:4] == 4'h3
		&& txChar.data == ctl_q[CTL_PAIR_BASE-1] && ctl_q[CTL_PAIR_BASE] != 8'h00;
	always_ff @(posedge sys_clk)
		if (!resetn)
			ctl_q <= '{default: 8'h00};
		else if (ctlWr)
			ctl_q[regAddr[4:0]] <= regWrData;
	always_ff @(posedge sys_clk)
		if (!resetn || ctlWr)
			rxt_q <= 1'b0;
		else if (rxTblWr)
			rxt_q <= 1'b1;
	always_ff @(posedge sys_clk)
		if (!resetn)
			gap_q <= '0;
		else if (pauseHit)
			gap_q <= ctl_q[CTL_PAIR_BASE] * DELAY_CYCLES;
		else if (gap_q != 0)
			gap_q <= gap_q - 1;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	mask_five_a: assert property (
		txCharValid && txChar.dataBits == DBITS_5 |-> txChar.data[7:5] == 3'h0) else $error("five bit mask");
	mask_six_a: assert property (
		txCharValid && txChar.dataBits == DBITS_6 |-> txChar.data[7:6] == 2'h0) else $error("six bit mask");
	mask_seven_a: assert property (
		txCharValid && txChar.dataBits == DBITS_7 |-> !txChar.data[7]) else $error("seven bit mask");
	format_follow_a: assert property (
		txCharValid |-> txChar.dataBits == ctl_q[CTL_FORMAT-1][7:4]) else $error("data bit count");
	tx_hold_a: assert property (
		txCharValid && !txCharAccept |=> txCharValid && $stable(txChar)) else $error("offer dropped");
	tx_gap_a: assert property (
		txCharValid && txCharAccept |=> !txCharValid) else $error("no gap after accept");
	pause_len_a: assert property (
		gap_q != 0 |-> !txCharValid) else $error("pause cut short");
	delim_clear_a: assert property (
		eorOn && regRd && regAddr == REG_RX_DATA |=> !regRdData[7]) else $error("delimiter top bit");
	idle_read_a: assert property (
		!regRd |=> regRdData == 8'h00) else $error("data without read");
	cover property (pauseHit);
	cover property (eorOn && regRd && regAddr == REG_RX_DATA);
	cover property (txCharValid && txChar.dataBits == DBITS_5 && txCharAccept);
endmodule

bind bac_char_proc bac_char_proc_sva #(.DELAY_CYCLES(DELAY_CYCLES)) bac_char_proc_sva_i (.sys_clk, .resetn,
	.regAddr, .regWrData, .regWr, .regRd, .regRdData, .hostTxReady, .rxCharValid, .rxChar, .txCharValid,
	.txChar, .txCharAccept);

/* File: sim/bac_link_model.sv */
`timescale 1ns/1ns
module bac_link_model (
	input	wire logic	sys_clk,
	input	wire logic	hold,
	input	wire logic	txCharValid,
	input	wire bac_pkg::bac_tx_char_t	txChar,
	output	logic	txCharAccept,
	output	logic	rxCharValid,
	output	bac_pkg::bac_rx_char_t	rxChar
);
	import bac_pkg::*;
	// ****************************************
	// serializer and deserializer stand-in
	// ****************************************
	logic [7:0]	txLog[$];
	int	txTime[$];
	initial
	begin
		txCharAccept = 1'b0;
		rxCharValid = 1'b0;
		rxChar = '0;
	end
	// hold stalls the serializer for as long as the bench wants
	always @(posedge sys_clk)
	begin
		if (txCharAccept && txCharValid)
		begin
			txLog.push_back(txChar.data);
			txTime.push_back(int'($time / 40));
		end
		txCharAccept <= txCharValid && !txCharAccept && !hold;
	end
	// between characters the lines carry the inverse, never a stale copy
	task automatic sendRx(input logic [7:0] d, input logic pe, input logic fe);
		@(posedge sys_clk);
		rxCharValid <= 1'b1;
		rxChar <= {d, pe, fe};
		@(posedge sys_clk);
		rxCharValid <= 1'b0;
		rxChar <= ~{d, pe, fe};
	endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	import bac_pkg::*;
	localparam int	DLY = 4;
	localparam logic [11:0]	FMT = 12'h002;
	logic	sys_clk = 1'b0;
	logic	resetn = 1'b0;
	logic [11:0]	regAddr = 12'h000;
	logic [7:0]	regWrData = 8'h00;
	logic	regWr = 1'b0;
	logic	regRd = 1'b0;
	logic	hold = 1'b0;
	logic [7:0]	regRdData;
	logic	hostTxReady;
	logic	rxCharValid;
	logic	txCharValid;
	logic	txCharAccept;
	bac_rx_char_t	rxChar;
	bac_tx_char_t	txChar;
	logic [7:0]	v;
	int	error_cnt = 0;
	int	n_checks = 0;
	int	i;
	int	n;
	int	g;
	always #20 sys_clk = ~sys_clk;
	bac_char_proc #(.DELAY_CYCLES(DLY)) bac_char_proc_i (.sys_clk, .resetn, .regAddr, .regWrData, .regWr,
		.regRd, .regRdData, .hostTxReady, .rxCharValid, .rxChar, .txCharValid, .txChar, .txCharAccept);
	bac_link_model bac_link_model_i (.sys_clk, .hold, .txCharValid, .txChar, .txCharAccept, .rxCharValid, .rxChar);
	// ****************************************
	// access tasks
	// ****************************************
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
		#1;
	endtask
	task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 v = regRdData;
		chk(nm, e, v);
	endtask
	task automatic rx(input logic [7:0] d, input logic pe = 1'b0, input logic fe = 1'b0);
		bac_link_model_i.sendRx(d, pe, fe);
	endtask
	task automatic waitTx(input int cnt);
		int k;
		for (k = 0; k < 5000 && bac_link_model_i.txLog.size() < cnt; k++)
			@(negedge sys_clk);
		if (k == 5000)
		begin
			error_cnt++;
			$display("MISMATCH tx count expected %0d seen timeout", cnt);
			print_verdict();
		end
	endtask
	task automatic txExp(input logic [7:0] e[$]);
		waitTx(e.size());
		repeat (16) @(negedge sys_clk);
		chk("tx count", 8'(e.size()), 8'(bac_link_model_i.txLog.size()));
		foreach (e[j])
			chk("tx char", e[j], bac_link_model_i.txLog[j]);
		bac_link_model_i.txLog.delete();
		bac_link_model_i.txTime.delete();
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rc("status", REG_STATUS, 8'h10);
		rc("subst byte", 12'h003, 8'h00);
		for (i = 0; i < 3; i++)
		begin
			wr(FMT, 8'(i << 4));
			wr(REG_TX_DATA, 8'hFF);
			txExp('{8'hFF >> (3 - i)});
		end
		wr(FMT, 8'h30);
		wr(REG_TX_DATA, 8'hA5);
		wr(12'h141, 8'h5A);
		wr(REG_TX_DATA, 8'h41);
		txExp('{8'hA5, 8'h5A});
		$display("tx format test done");
		wr(12'h00A, 8'h0D);
		wr(12'h00B, 8'h03);
		wr(REG_TX_DATA, 8'h0D);
		wr(REG_TX_DATA, 8'h41);
		wr(REG_TX_DATA, 8'h42);
		waitTx(3);
		g = bac_link_model_i.txTime[1] - bac_link_model_i.txTime[0];
		chk("paused gap", 8'h01, 8'(g >= 3 * DLY && g <= 3 * DLY + 8));
		g = bac_link_model_i.txTime[2] - bac_link_model_i.txTime[1];
		chk("plain gap", 8'h01, 8'(g < 3 * DLY));
		txExp('{8'h0D, 8'h41, 8'h42});
		$display("tx pause test done");
		wr(12'h003, 8'h40);
		rx(8'h33);
		rx(8'h77, 1'b1);
		rx(8'h88, 1'b0, 1'b1);
		rc("rx plain", REG_RX_DATA, 8'h33);
		rc("rx parity", REG_RX_DATA, 8'h40);
		rc("rx framing", REG_RX_DATA, 8'h40);
		rc("status", REG_STATUS, 8'h13);
		wr(12'h001, 8'h10);
		wr(12'h220, 8'h00);
		wr(12'h221, 8'h61);
		rx(8'h20);
		rx(8'h21);
		rc("null drop", REG_RX_DATA, 8'h61);
		rc("rx level", REG_RX_LEVEL, 8'h00);
		$display("rx substitution test done");
		wr(FMT, 8'h00);
		wr(12'h006, 8'h1B);
		wr(12'h007, 8'h1F);
		wr(12'h141, 8'h41);
		wr(12'h161, 8'h01);
		wr(12'h12E, 8'h8E);
		wr(12'h281, 8'h41);
		wr(12'h201, 8'h61);
		wr(REG_TX_DATA, 8'h61);
		wr(REG_TX_DATA, 8'h2E);
		wr(REG_TX_DATA, 8'h41);
		txExp('{8'h1F, 8'h01, 8'h0E, 8'h1B, 8'h01});
		rx(8'h1B);
		rx(8'h01);
		rx(8'h1F);
		rx(8'h01);
		rc("upshifted", REG_RX_DATA, 8'h41);
		rc("downshifted", REG_RX_DATA, 8'h61);
		rc("rx level", REG_RX_LEVEL, 8'h00);
		$display("shift test done");
		wr(FMT, 8'h30);
		wr(12'h005, EOR_ENABLE);
		wr(12'h241, 8'h41);
		wr(12'h242, 8'h42);
		wr(12'h20D, 8'h8D);
		rx(8'h41);
		rx(8'h0D);
		rx(8'h42);
		rc("records", REG_REC_COUNT, 8'h01);
		rc("record char", REG_RX_DATA, 8'h41);
		rc("delimiter", REG_RX_DATA, 8'h0D);
		rc("records", REG_REC_COUNT, 8'h00);
		rc("partial", REG_RX_DATA, 8'h00);
		rc("rx level", REG_RX_LEVEL, 8'h01);
		wr(12'h005, 8'h00);
		wr(12'h28D, 8'h8D);
		rx(8'h8D);
		rc("no records", REG_RX_DATA, 8'h42);
		rc("top bit kept", REG_RX_DATA, 8'h8D);
		$display("record test done");
		wr(FMT, 8'h30);
		rx(8'hA1);
		for (i = 0; i < RX_DEPTH; i++)
			rx(8'h3C);
		rc("rx level", REG_RX_LEVEL, 8'(RX_DEPTH));
		rc("overflow", REG_STATUS, 8'h1C);
		rc("head kept", REG_RX_DATA, 8'hA1);
		rc("rx level", REG_RX_LEVEL, 8'(RX_DEPTH - 1));
		$display("overflow test done");
		hold <= 1'b1;
		for (n = 0; n < 300 && hostTxReady === 1'b1; n++)
			wr(REG_TX_DATA, 8'(n));
		chk("tx capacity", 8'h01, 8'(n >= TX_DEPTH && n <= TX_DEPTH + 2));
		hold <= 1'b0;
		for (i = n; i < n + 10; i++)
		begin
			for (g = 0; g < 500 && hostTxReady !== 1'b1; g++)
				@(negedge sys_clk);
			if (g == 500)
			begin
				error_cnt++;
				$display("MISMATCH tx ready expected 1 seen timeout");
				print_verdict();
			end
			else
				wr(REG_TX_DATA, 8'(i));
		end
		waitTx(n + 10);
		for (i = 0; i < n + 10; i++)
			chk("tx order", 8'(i), bac_link_model_i.txLog[i]);
		$display("tx stall test done");
		print_verdict();
	end
endmodule
